/* File: design/sew_cfg.svh */
// Constants of the two-wire serial memory target
`ifndef SEW_CFG_SVH
`define SEW_CFG_SVH
`define SEW_CLK_HZ 50000000
`define SEW_WR_TIME_MS 10
`define SEW_DEV_TYPE 4'ha
`define SEW_DEV_TYPE_LSB 4
`define SEW_DEV_SEL_LSB 1
`define SEW_DEV_RW_BIT 0
`define SEW_ADDR_W 13
`define SEW_PAGE_W 5
`define SEW_PAGE_BYTES 32
`define SEW_MEM_BYTES 8192
`define SEW_BYTE_BITS 4'h8
`define SEW_PROT_QUAD 2'h3
`define SEW_TIMER_W 20
`define SEW_NSYNC 6
`endif

/* File: design/sew_pkg.sv */
// Types shared by the two-wire serial memory target
`include "sew_cfg.svh"
package sew_pkg;
    typedef logic [`SEW_ADDR_W-1:0] sew_addr_t;
    typedef logic [7:0] sew_byte_t;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_AHI,
        ST_AHI_ACK,
        ST_ALO,
        ST_ALO_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RACK,
        ST_RNEXT
    } sew_state_e;
endpackage

/* File: design/sew_mem.sv */
// Byte array standing in for the memory cells
`include "sew_cfg.svh"
module sew_mem
    import sew_pkg::*;
(
    input wire logic clk_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire sew_addr_t waddr_i,
    input wire sew_byte_t wdata_i,
    input wire sew_addr_t raddr_i,
    output sew_byte_t rdata_o
);
    sew_byte_t cells [0:`SEW_MEM_BYTES-1];

    // Registered read; address is stable long before it is used
    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            if (we_i)
            begin
                cells[waddr_i] <= wdata_i;
            end
            rdata_o <= cells[raddr_i];
        end
    end
endmodule

/* File: design/sew_target.sv */
// Two-wire target front end, access control and self-timed write
`include "sew_cfg.svh"

// Contract
// [R01] Data falling while clock high is a start; every command begins with one.
// [R02] Data rising while clock high is a stop; returns device to standby.
// [R03] Data changes only while clock low; a change while high is start or stop.
// [R04] Words are 8 bits; device drives data low on ninth clock to acknowledge.
// [R05] Standby at power-up and after stop once internal work is finished.
// [R06] Controller recovers bus with up to 9 clocks then a start.
// [R07] Device address word begins with a fixed four-bit type pattern.
// [R08] Next three bits must equal the device-select pins; floating pins read low.
// [R09] Last address bit chooses direction: one reads, zero writes.
// [R10] Matching address is acknowledged; a mismatch stays silent and idles.
// [R11] Write-protect high refuses writes to the upper quarter of memory.
// [R12] Byte write: two address bytes, one data byte, stop; each acknowledged.
// [R13] Stop after write runs a timed cycle; inputs ignored, nothing acknowledged.
// [R14] Page write takes up to 32 data bytes, each acknowledged, then stop.
// [R15] Write address advances in low five bits only, wrapping inside page.
// [R16] Address polling during write cycle is acknowledged only once it ends.
// [R17] Address counter holds last accessed address plus one between operations.
// [R18] Read address wraps from the last byte to the very first byte.
// [R19] Current-address read sends byte at counter after acknowledged read address.
// [R20] Random read is a dummy write of address, repeated start, then read.
// [R21] Controller acknowledge advances sequential read; no acknowledge ends it.
// [R22] Inputs sampled on clock rise; outputs changed after clock fall.
// [R23] Memory is 256 pages of 32 bytes with a 13-bit word address.
// [R24] Address bits above the word address width are ignored.
// [R25] Start mid-transfer aborts and restarts address reception, no write cycle.
module sew_target
    import sew_pkg::*;
#(
    parameter int WRITE_CYCLES = `SEW_WR_TIME_MS * (`SEW_CLK_HZ / 1000)
)
(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] device_select_pins_i,
    input wire logic write_protect_i,
    output logic standby_o,
    output logic write_busy_o
);
    localparam logic [`SEW_TIMER_W-1:0] WR_LAST = `SEW_TIMER_W'(WRITE_CYCLES - 1);
    localparam logic [`SEW_TIMER_W-1:0] PAGE_END = `SEW_TIMER_W'(`SEW_PAGE_BYTES);

    function automatic logic sew_dev_match(input sew_byte_t b, input logic [2:0] sel);
        sew_dev_match = (b[7:`SEW_DEV_TYPE_LSB] == `SEW_DEV_TYPE)
            && (b[`SEW_DEV_TYPE_LSB-1:`SEW_DEV_SEL_LSB] == sel);
    endfunction

    function automatic logic sew_protected(input logic wp, input sew_addr_t a);
        sew_protected = wp && (a[`SEW_ADDR_W-1:`SEW_ADDR_W-2] == `SEW_PROT_QUAD);
    endfunction

    logic [`SEW_NSYNC-1:0] pin_raw;
    logic [`SEW_NSYNC-1:0] sync_meta;
    logic [`SEW_NSYNC-1:0] sync_q;
    logic scl_q;
    logic sda_q;
    logic scl_prev;
    logic sda_prev;
    logic [2:0] sel_q;
    logic wp_q;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic rx_state;
    logic rx_done;
    logic load_rd;
    logic wbyte_ev;
    logic launch;
    sew_state_e state;
    logic [3:0] bit_cnt;
    sew_byte_t shreg;
    sew_byte_t addr_hi;
    sew_byte_t rd_byte;
    sew_addr_t addr;
    logic rw;
    logic sda_drive;
    sew_byte_t page_buf [0:`SEW_PAGE_BYTES-1];
    logic [`SEW_PAGE_BYTES-1:0] wr_mask;
    logic wr_armed;
    logic [`SEW_ADDR_W-`SEW_PAGE_W-1:0] wr_page;
    logic wr_busy;
    logic [`SEW_TIMER_W-1:0] wr_timer;
    logic mem_we;
    sew_addr_t mem_waddr;
    sew_byte_t mem_wdata;
    sew_byte_t mem_rdata;

    // Pins come from outside the clock domain; two stages each
    assign pin_raw = {write_protect_i, device_select_pins_i, sda_i, scl_i};
    // Link pins reset to their idle high level so no false edge follows reset

    generate
        for (genvar g = 0; g < `SEW_NSYNC; g++)
        begin : g_sync
            always_ff @(posedge ref_clk_i)
            begin
                if (reset_i)
                begin
                    sync_meta[g] <= (g < 2) ? 1'b1 : 1'b0;
                    sync_q[g] <= (g < 2) ? 1'b1 : 1'b0;
                end
                else if (clk_en_i)
                begin
                    sync_meta[g] <= pin_raw[g];
                    sync_q[g] <= sync_meta[g];
                end
            end
        end
    endgenerate

    assign scl_q = sync_q[0];
    assign sda_q = sync_q[1];
    assign sel_q = sync_q[4:2]; // [R08]
    assign wp_q = sync_q[5];

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else if (clk_en_i)
        begin
            scl_prev <= scl_q;
            sda_prev <= sda_q;
        end
    end

    // Data edges with the clock high are framing, never data
    assign start_ev = scl_q && scl_prev && sda_prev && !sda_q; // [R01] [R03]
    assign stop_ev = scl_q && scl_prev && !sda_prev && sda_q; // [R02] [R03]
    assign scl_rise = scl_q && !scl_prev;
    assign scl_fall = !scl_q && scl_prev;
    assign rx_state = (state == ST_DEV) || (state == ST_AHI) || (state == ST_ALO)
        || (state == ST_WDATA);
    assign rx_done = scl_fall && (bit_cnt == `SEW_BYTE_BITS);
    assign load_rd = scl_fall && (((state == ST_DEV_ACK) && rw) || (state == ST_RNEXT));
    assign wbyte_ev = !start_ev && !stop_ev && (state == ST_WDATA) && rx_done
        && !sew_protected(wp_q, addr); // [R11]
    assign launch = stop_ev && wr_armed && !wr_busy; // [R13]

    // Protocol engine
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            addr_hi <= 8'h00;
            rd_byte <= 8'h00;
            addr <= '0;
            rw <= 1'b0;
            sda_drive <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (start_ev)
            begin
                state <= ST_DEV; // [R01] [R25]
                bit_cnt <= 4'h0;
                sda_drive <= 1'b0;
            end
            else if (stop_ev)
            begin
                state <= ST_IDLE; // [R02]
                sda_drive <= 1'b0;
            end
            else if (load_rd)
            begin
                // Counter moves past the byte as it leaves
                state <= ST_RDATA; // [R19] [R21]
                rd_byte <= mem_rdata;
                sda_drive <= !mem_rdata[7]; // [R22]
                addr <= addr + 1'b1; // [R17] [R18]
                bit_cnt <= 4'h0;
            end
            else
            begin
                if (rx_state && scl_rise)
                begin
                    shreg <= {shreg[6:0], sda_q}; // [R22]
                    bit_cnt <= bit_cnt + 4'h1;
                end
                case (state)
                    ST_IDLE:
                    begin
                    end
                    ST_DEV:
                    begin
                        if (rx_done)
                        begin
                            bit_cnt <= 4'h0;
                            // Busy write cycle keeps polls unanswered
                            if (sew_dev_match(shreg, sel_q) && !wr_busy) // [R07] [R08] [R16]
                            begin
                                rw <= shreg[`SEW_DEV_RW_BIT]; // [R09]
                                state <= ST_DEV_ACK;
                                sda_drive <= 1'b1; // [R04] [R10]
                            end
                            else
                            begin
                                state <= ST_IDLE; // [R10] [R13]
                            end
                        end
                    end
                    ST_AHI:
                    begin
                        if (rx_done)
                        begin
                            bit_cnt <= 4'h0;
                            addr_hi <= shreg; // [R12]
                            state <= ST_AHI_ACK;
                            sda_drive <= 1'b1; // [R04]
                        end
                    end
                    ST_ALO:
                    begin
                        if (rx_done)
                        begin
                            bit_cnt <= 4'h0;
                            addr <= {addr_hi[`SEW_ADDR_W-9:0], shreg}; // [R23] [R24] [R20]
                            state <= ST_ALO_ACK;
                            sda_drive <= 1'b1; // [R04]
                        end
                    end
                    ST_WDATA:
                    begin
                        if (rx_done)
                        begin
                            bit_cnt <= 4'h0;
                            addr[`SEW_PAGE_W-1:0] <= addr[`SEW_PAGE_W-1:0] + 1'b1; // [R15]
                            state <= ST_WDATA_ACK;
                            sda_drive <= 1'b1; // [R04] [R14]
                        end
                    end
                    ST_DEV_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_drive <= 1'b0;
                            state <= ST_AHI;
                        end
                    end
                    ST_AHI_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_drive <= 1'b0;
                            state <= ST_ALO;
                        end
                    end
                    ST_ALO_ACK, ST_WDATA_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_drive <= 1'b0;
                            state <= ST_WDATA;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (scl_rise)
                        begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            if (bit_cnt == `SEW_BYTE_BITS)
                            begin
                                sda_drive <= 1'b0;
                                state <= ST_RACK;
                            end
                            else
                            begin
                                sda_drive <= !rd_byte[~bit_cnt[2:0]]; // [R22]
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            state <= sda_q ? ST_IDLE : ST_RNEXT; // [R21]
                        end
                    end
                    ST_RNEXT:
                    begin
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Page buffer: data stays here until the stop, so an abort writes nothing
    always_ff @(posedge ref_clk_i)
    begin
        if (clk_en_i && wbyte_ev)
        begin
            page_buf[addr[`SEW_PAGE_W-1:0]] <= shreg;
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            wr_mask <= '0;
            wr_armed <= 1'b0;
            wr_page <= '0;
        end
        else if (clk_en_i)
        begin
            if (start_ev && !wr_busy)
            begin
                wr_mask <= '0; // [R25]
                wr_armed <= 1'b0;
            end
            else if (wbyte_ev)
            begin
                wr_mask[addr[`SEW_PAGE_W-1:0]] <= 1'b1; // [R15]
                wr_armed <= 1'b1;
                wr_page <= addr[`SEW_ADDR_W-1:`SEW_PAGE_W];
            end
            else if (wr_busy && (wr_timer == WR_LAST))
            begin
                wr_mask <= '0;
                wr_armed <= 1'b0;
            end
        end
    end

    // Self-timed cycle; committed bytes go out in its first cycles
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            wr_busy <= 1'b0;
            wr_timer <= '0;
        end
        else if (clk_en_i)
        begin
            if (launch)
            begin
                wr_busy <= 1'b1; // [R13]
                wr_timer <= '0;
            end
            else if (wr_busy)
            begin
                if (wr_timer == WR_LAST)
                begin
                    wr_busy <= 1'b0;
                end
                else
                begin
                    wr_timer <= wr_timer + 1'b1;
                end
            end
        end
    end

    assign mem_we = wr_busy && (wr_timer < PAGE_END) && wr_mask[wr_timer[`SEW_PAGE_W-1:0]];
    assign mem_waddr = {wr_page, wr_timer[`SEW_PAGE_W-1:0]};
    assign mem_wdata = page_buf[wr_timer[`SEW_PAGE_W-1:0]];

    sew_mem u_mem (
        .clk_i(ref_clk_i),
        .ce_i(clk_en_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .raddr_i(addr),
        .rdata_o(mem_rdata)
    );

    // Open drain: only ever pulls low
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
            standby_o <= 1'b1;
            write_busy_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            sda_o <= 1'b0;
            sda_oe_o <= sda_drive;
            standby_o <= (state == ST_IDLE) && !wr_busy; // [R05]
            write_busy_o <= wr_busy;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_dev_byte_done;
        clk_en_i && !start_ev && !stop_ev && (state == ST_DEV) && rx_done;
    endsequence

    sequence s_wdata_byte_done;
        clk_en_i && !start_ev && !stop_ev && (state == ST_WDATA) && rx_done;
    endsequence

    chk_ack_on_match: assert property (s_dev_byte_done ##0 (sew_dev_match(shreg, sel_q) // [R10]
        && !wr_busy) |=> (state == ST_DEV_ACK) ##1 sda_oe_o)
        else $error("matching device address not acknowledged");
    chk_silent_mismatch: assert property (s_dev_byte_done ##0 !sew_dev_match(shreg, sel_q) // [R10]
        |=> (state == ST_IDLE) && !sda_drive)
        else $error("mismatched address not ignored");
    chk_no_ack_busy: assert property (wr_busy |-> (state != ST_DEV_ACK)) // [R13]
        else $error("acknowledge during write cycle");
    chk_start_abort: assert property (clk_en_i && start_ev && !wr_busy // [R25]
        |=> (state == ST_DEV) && (bit_cnt == 4'h0) && !wr_armed)
        else $error("start did not abort transfer");
    chk_stop_idle: assert property (clk_en_i && stop_ev |=> (state == ST_IDLE) ##1 // [R02]
        (standby_o == !wr_busy))
        else $error("stop did not return to idle");
    chk_page_wrap: assert property (s_wdata_byte_done |=> // [R15]
        (addr[`SEW_PAGE_W-1:0] == `SEW_PAGE_W'($past(addr[`SEW_PAGE_W-1:0]) + 1'b1))
        && (addr[`SEW_ADDR_W-1:`SEW_PAGE_W] == $past(addr[`SEW_ADDR_W-1:`SEW_PAGE_W])))
        else $error("write address left its page");
    chk_read_wrap: assert property (clk_en_i && !start_ev && !stop_ev && load_rd // [R18]
        |=> addr == `SEW_ADDR_W'($past(addr) + 1'b1))
        else $error("read address did not advance");
    chk_protect: assert property (s_wdata_byte_done ##0 sew_protected(wp_q, addr) // [R11]
        |=> wr_armed == $past(wr_armed))
        else $error("protected write was accepted");
    chk_write_time: assert property ($fell(wr_busy) |-> $past(wr_timer) == WR_LAST) // [R13]
        else $error("write cycle length wrong");
    chk_ack_driven: assert property ((state == ST_DEV_ACK) || (state == ST_WDATA_ACK) // [R04]
        |=> sda_oe_o)
        else $error("acknowledge slot not driven low");
    chk_sample_rise: assert property (clk_en_i && rx_state && scl_rise && !start_ev // [R22]
        && !stop_ev |=> shreg[0] == $past(sda_q))
        else $error("data not sampled on clock rise");
endmodule

/* File: test/sew_ctl_model.sv */
// Two-wire bus controller model that drives the serial clock and pulls the data line
module sew_ctl_model
(
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Clock idles high between frames, data released to the pull-up
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // Data moves only with clock low; sampled late in the high phase
    task automatic bit_io(input logic b, output logic s);
        tick(2);
        sda_oe_o = !b;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        s = sda_i;
        scl_o = 1'b0;
    endtask

    // Data falls while clock high
    task automatic start();
        tick(2);
        sda_oe_o = 1'b0;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b1;
        tick(4);
        scl_o = 1'b0;
    endtask

    // Data rises while clock high; gap kept before next frame
    task automatic stop();
        tick(2);
        sda_oe_o = 1'b1;
        tick(2);
        scl_o = 1'b1;
        tick(4);
        sda_oe_o = 1'b0;
        tick(8);
    endtask

    // Eight bits MSB first, then the target's answer bit
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = !s;
    endtask

    // Controller answers low for more, high to end the read
    task automatic get_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(!mack, s);
    endtask

    // Up to nine clocks until data reads high, then a start
    task automatic recover();
        logic s;
        sda_oe_o = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            bit_io(1'b1, s);
            if (s)
                break;
        end
        start();
    endtask
endmodule

/* File: test/tb_sew_target.sv */
// Self-checking bench for the two-wire serial memory target
`include "sew_cfg.svh"
module tb_sew_target;
    timeunit 1ns;
    timeprecision 1ps;

    // Short write cycle, still long enough for a poll to land inside it
    localparam int WCYC = 400;
    localparam logic [2:0] SEL = 3'h5;
    typedef struct {logic [15:0] wa; logic [15:0] ra; logic [7:0] d; logic wp; logic [7:0] e;} sew_row_s;

    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic wp = 1'b0;
    logic en = 1'b1;
    logic scl;
    logic ctl_oe;
    logic dut_sda;
    logic dut_oe;
    logic standby;
    logic busy;
    logic ack;
    logic [7:0] rd_q [$];
    int fail_count = 0;
    int compares = 0;
    // Open-drain wire with pull-up
    wire sda_bus = (dut_oe ? dut_sda : 1'b1) & !ctl_oe;

    sew_row_s rows [7] = '{
        '{16'h0123, 16'h0123, 8'h5a, 1'b0, 8'h5a},
        '{16'h0000, 16'h0000, 8'h77, 1'b0, 8'h77},
        '{16'h1800, 16'h1800, 8'h11, 1'b0, 8'h11},
        '{16'h1800, 16'h1800, 8'h22, 1'b1, 8'h11},
        '{16'h17ff, 16'h17ff, 8'h33, 1'b1, 8'h33},
        '{16'h1fff, 16'h1fff, 8'h44, 1'b0, 8'h44},
        '{16'he0c0, 16'h00c0, 8'h66, 1'b0, 8'h66}
    };

    always #10 ref_clk = !ref_clk;

    sew_target #(.WRITE_CYCLES(WCYC)) sew_target_i (
        .ref_clk_i(ref_clk), .reset_i(reset), .clk_en_i(en), .scl_i(scl),
        .sda_i(sda_bus), .sda_o(dut_sda), .sda_oe_o(dut_oe),
        .device_select_pins_i(SEL), .write_protect_i(wp),
        .standby_o(standby), .write_busy_o(busy));

    sew_ctl_model sew_ctl_model_i (.ref_clk_i(ref_clk), .sda_i(sda_bus),
        .scl_o(scl), .sda_oe_o(ctl_oe));

    task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic check_b(input string n, input logic e, input logic s);
        check(n, {7'h0, e}, {7'h0, s});
    endtask

    task automatic dev(input logic [3:0] ty, input logic [2:0] s, input logic rw);
        sew_ctl_model_i.start();
        sew_ctl_model_i.put_byte({ty, s, rw}, ack);
    endtask

    task automatic set_addr(input logic [15:0] a);
        dev(`SEW_DEV_TYPE, SEL, 1'b0);
        check_b("dev ack", 1'b1, ack);
        sew_ctl_model_i.put_byte(a[15:8], ack);
        check_b("hi ack", 1'b1, ack);
        sew_ctl_model_i.put_byte(a[7:0], ack);
        check_b("lo ack", 1'b1, ack);
    endtask

    task automatic write(input logic [15:0] a, input logic [7:0] d);
        set_addr(a);
        sew_ctl_model_i.put_byte(d, ack);
        check_b("data ack", 1'b1, ack);
        sew_ctl_model_i.stop();
    endtask

    // Poll until answered; tries returned so a refused first poll shows
    task automatic poll(output int n);
        n = 0;
        do
        begin
            dev(`SEW_DEV_TYPE, SEL, 1'b0);
            n++;
        end while (!ack && n < 20);
        sew_ctl_model_i.stop();
    endtask

    task automatic cur_read(input int n);
        logic [7:0] d;
        rd_q.delete();
        dev(`SEW_DEV_TYPE, SEL, 1'b1);
        check_b("rd ack", 1'b1, ack);
        for (int i = 0; i < n; i++)
        begin
            sew_ctl_model_i.get_byte(i < n - 1, d);
            rd_q.push_back(d);
        end
        sew_ctl_model_i.stop();
    endtask

    // Dummy write loads the address, repeated start turns to reading
    task automatic read(input logic [15:0] a, input int n);
        set_addr(a);
        cur_read(n);
    endtask

    task automatic results();
        $display("mismatches %0d comparisons %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        int n;
        logic [7:0] e;
        repeat (10) @(negedge ref_clk);
        reset = 1'b0;
        check_b("standby", 1'b1, standby);
        check_b("busy", 1'b0, busy);
        check_b("sda drive", 1'b0, dut_oe);
        repeat (4) @(negedge ref_clk);
        sew_ctl_model_i.recover();
        sew_ctl_model_i.stop();
        foreach (rows[i])
        begin
            wp = rows[i].wp;
            write(rows[i].wa, rows[i].d);
            poll(n);
            read(rows[i].ra, 1);
            check("row data", rows[i].e, rd_q[0]);
        end
        wp = 1'b0;
        // Wrong type pattern, then every select value
        dev(4'h5, SEL, 1'b0);
        check_b("type nack", 1'b0, ack);
        for (int s = 0; s < 8; s++)
        begin
            dev(`SEW_DEV_TYPE, 3'(s), 1'b0);
            check_b("select", 3'(s) == SEL, ack);
        end
        sew_ctl_model_i.stop();
        check_b("standby", 1'b1, standby);
        read(16'h1fff, 2);
        check("wrap hi", 8'h44, rd_q[0]);
        check("wrap lo", 8'h77, rd_q[1]);
        // Write cycle refuses the first poll
        write(16'h0200, 8'hc3);
        repeat (8) @(negedge ref_clk);
        check_b("busy", 1'b1, busy);
        check_b("standby", 1'b0, standby);
        // Enable low freezes the write timer; longer than the whole cycle
        en = 1'b0;
        repeat (WCYC + 100) @(negedge ref_clk);
        check_b("frozen", 1'b1, busy);
        check_b("sda level", 1'b0, dut_sda);
        en = 1'b1;
        poll(n);
        check_b("poll nack", 1'b1, n > 1);
        check_b("idle", 1'b0, busy);
        // 33 bytes from offset 5: the last one lands on offset 5 again
        set_addr(16'h0025);
        for (int i = 0; i < 33; i++)
        begin
            sew_ctl_model_i.put_byte(8'(i + 1), ack);
            check_b("page ack", 1'b1, ack);
        end
        sew_ctl_model_i.stop();
        poll(n);
        cur_read(1);
        check("after write", 8'h02, rd_q[0]);
        read(16'h0020, 31);
        foreach (rd_q[o])
        begin
            e = ((o + 27) % 32 == 0) ? 8'h21 : 8'((o + 27) % 32 + 1);
            check("page data", e, rd_q[o]);
        end
        cur_read(1);
        check("current", 8'h1b, rd_q[0]);
        // Repeated start after a data byte drops the write
        set_addr(16'h0123);
        sew_ctl_model_i.put_byte(8'h99, ack);
        sew_ctl_model_i.start();
        sew_ctl_model_i.stop();
        repeat (20) @(negedge ref_clk);
        check_b("no cycle", 1'b0, busy);
        read(16'h0123, 1);
        check("kept", 8'h5a, rd_q[0]);
        results();
    end

    // Whole run needs well under a millisecond
    initial
    begin
        #1500000;
        fail_count++;
        results();
    end
endmodule
